//--- itu_pkg.sv
package itu_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] ITU_OFF_STATUS_WORD = 8'h00;
   localparam logic [7:0] ITU_OFF_CONTROL     = 8'h04;
   localparam logic [7:0] ITU_OFF_STACK_PTR   = 8'h08;
   localparam logic [7:0] ITU_OFF_EVENTS      = 8'h0c;
   localparam logic [7:0] ITU_OFF_EVENT_MASK  = 8'h10;
   localparam logic [7:0] ITU_OFF_PROG_CNT    = 8'h14;

   // processor status word fields
   localparam int ITU_PSW_GIE  = 0;
   localparam int ITU_PSW_ENI  = 1;
   localparam int ITU_PSW_EXT_IRQ_PENDING = 2;
   localparam int ITU_PSW_TIMER_IRQ_ENABLE = 4;
   localparam int ITU_PSW_TIMER_IRQ_PENDING = 5;
   // control register field: external interrupt edge select, set for falling edge
   localparam int ITU_CTL_EDGE = 2;

   // event status and mask fields
   localparam int ITU_EV_EXT   = 0;
   localparam int ITU_EV_TIMER = 1;
   localparam int ITU_EV_TRAP  = 2;
   localparam int ITU_EV_ACK   = 3;
   localparam int ITU_EV_W     = 4;

   // reset values
   localparam logic [7:0]          ITU_RST_BYTE  = 8'h00;
   localparam logic [ITU_EV_W-1:0] ITU_RST_EV    = 4'h0;
   localparam logic [14:0]         ITU_RST_PC    = 15'h0000;

   // fixed values of the sequencer
   localparam logic [14:0] ITU_VECTOR      = 15'h00ff;
   localparam logic [7:0]  ITU_TRAP_OPCODE = 8'h00;
   localparam logic [7:0]  ITU_ROM_BLANK   = 8'h00;
   localparam logic [7:0]  ITU_RAM_BLANK   = 8'hff;
   localparam logic [2:0]  ITU_ACK_CYCLES  = 3'h7;
   localparam logic [7:0]  ITU_SP_STEP     = 8'h02;

   typedef enum logic [1:0] {
      ITU_ST_IDLE = 2'b00,
      ITU_ST_ACK  = 2'b01,
      ITU_ST_POP  = 2'b10
   } itu_state_e;

   typedef enum logic [1:0] {
      ITU_RET_PLAIN = 2'b00,
      ITU_RET_SKIP  = 2'b01,
      ITU_RET_IRQ   = 2'b10
   } itu_ret_e;

   // stack memory port towards the RAM
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } itu_stack_s;

   // program counter load towards the core sequencer
   typedef struct packed {
      logic        load;
      logic        skip;
      logic [14:0] value;
   } itu_pc_load_s;

endpackage

//--- itu_irq_trap_unit.sv
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps

module itu_irq_trap_unit
   import itu_pkg::*;
#(
   parameter int ROM_SIZE = 4096,
   parameter int RAM_SIZE = 128
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         reset_in,
   // avalon-mm slave
   input  wire logic [7:0]   address_in,
   input  wire logic         read_in,
   input  wire logic         write_in,
   input  wire logic [3:0]   byteenable_in,
   input  wire logic [31:0]  writedata_in,
   output logic [31:0]       readdata_out,
   output logic              waitrequest_out,
   // interrupt sources
   input  wire logic         ext_irq_pin_in,
   input  wire logic         timer_event_in,
   // core sequencer
   input  wire logic         boundary_in,
   input  wire logic         exec_valid_in,
   input  wire logic [7:0]   exec_opcode_in,
   input  wire logic [14:0]  pc_in,
   input  wire logic         ret_valid_in,
   input  wire logic [1:0]   ret_kind_in,
   output logic              busy_out,
   output itu_pc_load_s      pc_load_out,
   // stack memory port
   output itu_stack_s        stack_out,
   input  wire logic [7:0]   stack_rdata_in,
   // memory read filters
   input  wire logic [14:0]  rom_addr_in,
   input  wire logic [7:0]   rom_data_in,
   output logic [7:0]        rom_data_out,
   input  wire logic [7:0]   ram_addr_in,
   input  wire logic [7:0]   ram_data_in,
   output logic [7:0]        ram_data_out,
   // interrupt to host
   output logic              irq_out
);

   typedef struct packed {
      logic [2:0]          pin_sync;
      logic [7:0]          processor_status_word;
      logic [7:0]          ctrl;
      logic [7:0]          sp;
      logic [ITU_EV_W-1:0] events;
      logic [ITU_EV_W-1:0] mask;
      logic [14:0]         pc_seen;
      itu_state_e          state;
      logic [2:0]          cnt;
      itu_ret_e            ret_kind;
      logic [7:0]          pop_lo;
      logic [7:0]          prev_addr;
      logic                wait_n;
      logic [31:0]         rdata;
      logic                busy;
      itu_pc_load_s        pc_load;
      itu_stack_s          stack;
      logic [7:0]          rom_data;
      logic [7:0]          ram_data;
      logic                irq;
   } itu_regs_s;

   itu_regs_s r_q;
   itu_regs_s r_d;

   logic        req;
   logic        bus_take;
   logic        ext_edge;
   logic        hw_take;
   logic        trap_take;
   logic [7:0]  stack_rd;
   logic [ITU_EV_W-1:0] ev_set;

   always_comb begin
      r_d        = r_q;
      req        = read_in | write_in;
      // a request is taken on the edge where waitrequest is already low
      bus_take   = req & ~r_q.wait_n;
      ext_edge   = 1'b0;
      hw_take    = 1'b0;
      trap_take  = 1'b0;
      ev_set     = ITU_RST_EV;
      stack_rd   = stack_rdata_in;

      // only the settled second/third stages feed the edge detector
      r_d.pin_sync = {r_q.pin_sync[1:0], ext_irq_pin_in};
      if (r_q.pin_sync[1] != r_q.pin_sync[2]) begin
         ext_edge = r_q.pin_sync[1] ^ r_q.ctrl[ITU_CTL_EDGE];
      end

      // single-cycle wait state on every access; waitrequest idles high
      r_d.wait_n = ~(req & r_q.wait_n);
      // read data holds until the next read so the master may take it late
      if (req & r_q.wait_n & read_in) begin
         case (address_in)
            ITU_OFF_STATUS_WORD: r_d.rdata = {24'h00_0000, r_q.processor_status_word};
            ITU_OFF_CONTROL:     r_d.rdata = {24'h00_0000, r_q.ctrl};
            ITU_OFF_STACK_PTR:   r_d.rdata = {24'h00_0000, r_q.sp};
            ITU_OFF_EVENTS:      r_d.rdata = {28'h000_0000, r_q.events};
            ITU_OFF_EVENT_MASK:  r_d.rdata = {28'h000_0000, r_q.mask};
            ITU_OFF_PROG_CNT:    r_d.rdata = {17'h0_0000, r_q.pc_seen};
            default:             r_d.rdata = 32'h0000_0000;
         endcase
      end

      // software writes; hardware updates below override them
      if (bus_take & write_in & byteenable_in[0]) begin
         case (address_in)
            ITU_OFF_STATUS_WORD: r_d.processor_status_word  = writedata_in[7:0];
            ITU_OFF_CONTROL:     r_d.ctrl = writedata_in[7:0];
            ITU_OFF_STACK_PTR:   r_d.sp   = writedata_in[7:0];
            ITU_OFF_EVENT_MASK:  r_d.mask = writedata_in[ITU_EV_W-1:0];
            default:             r_d.mask = r_d.mask;
         endcase
      end
      if (bus_take & read_in & (address_in == ITU_OFF_EVENTS)) begin
         r_d.events = ITU_RST_EV;
      end

      // pending flags: a source event wins over a clearing write
      if (ext_edge) begin
         r_d.processor_status_word[ITU_PSW_EXT_IRQ_PENDING] = 1'b1;
      end
      if (timer_event_in) begin
         r_d.processor_status_word[ITU_PSW_TIMER_IRQ_PENDING] = 1'b1;
      end

      r_d.pc_load.load = 1'b0;
      r_d.pc_load.skip = 1'b0;
      r_d.stack.wr     = 1'b0;
      r_d.stack.rd     = 1'b0;
      r_d.prev_addr    = r_q.stack.addr;

      case (r_q.state)
         ITU_ST_IDLE: begin
            hw_take = boundary_in & r_q.processor_status_word[ITU_PSW_GIE] &
                      ((r_q.processor_status_word[ITU_PSW_ENI] & r_q.processor_status_word[ITU_PSW_EXT_IRQ_PENDING]) |
                       (r_q.processor_status_word[ITU_PSW_TIMER_IRQ_ENABLE] & r_q.processor_status_word[ITU_PSW_TIMER_IRQ_PENDING]));
            trap_take = exec_valid_in & (exec_opcode_in == ITU_TRAP_OPCODE);
            if (hw_take | trap_take) begin
               r_d.state       = ITU_ST_ACK;
               r_d.cnt         = 3'h0;
               r_d.busy        = 1'b1;
               r_d.pc_seen     = pc_in;
               // high byte first, the stack grows toward lower addresses
               r_d.stack.wr    = 1'b1;
               r_d.stack.addr  = r_q.sp;
               r_d.stack.wdata = {1'b0, pc_in[14:8]};
               if (hw_take) begin
                  r_d.processor_status_word[ITU_PSW_GIE] = 1'b0;
               end
               // a trap does not touch the global enable
            end else if (ret_valid_in) begin
               r_d.state      = ITU_ST_POP;
               r_d.cnt        = 3'h0;
               r_d.busy       = 1'b1;
               r_d.ret_kind   = itu_ret_e'(ret_kind_in);
               r_d.stack.rd   = 1'b1;
               r_d.stack.addr = 8'(r_q.sp + 8'h01);
            end
         end
         ITU_ST_ACK: begin
            r_d.cnt = 3'(r_q.cnt + 3'h1);
            if (r_q.cnt == 3'h0) begin
               r_d.stack.wr    = 1'b1;
               r_d.stack.addr  = 8'(r_q.sp - 8'h01);
               r_d.stack.wdata = r_q.pc_seen[7:0];
               r_d.sp          = 8'(r_q.sp - ITU_SP_STEP);
            end
            // the vector load lands in the last of the seven cycles
            if (r_q.cnt == 3'(ITU_ACK_CYCLES - 3'h2)) begin
               r_d.pc_load.load  = 1'b1;
               r_d.pc_load.value = ITU_VECTOR;
            end
            if (r_q.cnt == 3'(ITU_ACK_CYCLES - 3'h1)) begin
               r_d.state = ITU_ST_IDLE;
               r_d.busy  = 1'b0;
            end
         end
         ITU_ST_POP: begin
            r_d.cnt = 3'(r_q.cnt + 3'h1);
            // stack data read past the RAM looks like erased memory
            if (int'(r_q.prev_addr) >= RAM_SIZE) begin
               stack_rd = ITU_RAM_BLANK;
            end
            if (r_q.cnt == 3'h0) begin
               r_d.stack.rd   = 1'b1;
               r_d.stack.addr = 8'(r_q.sp + ITU_SP_STEP);
            end else if (r_q.cnt == 3'h1) begin
               r_d.pop_lo = stack_rd;
            end else begin
               r_d.pc_load.load  = 1'b1;
               r_d.pc_load.value = {stack_rd[6:0], r_q.pop_lo};
               // skip is for trap handlers so the zero opcode is not rerun
               r_d.pc_load.skip  = (r_q.ret_kind == ITU_RET_SKIP);
               r_d.sp            = 8'(r_q.sp + ITU_SP_STEP);
               if (r_q.ret_kind == ITU_RET_IRQ) begin
                  r_d.processor_status_word[ITU_PSW_GIE] = 1'b1;
               end
               r_d.state = ITU_ST_IDLE;
               r_d.busy  = 1'b0;
            end
         end
         default: begin
            r_d.state = ITU_ST_IDLE;
            r_d.busy  = 1'b0;
         end
      endcase

      // event status: hardware setting wins over the read clear
      ev_set[ITU_EV_EXT]   = ext_edge;
      ev_set[ITU_EV_TIMER] = timer_event_in;
      ev_set[ITU_EV_TRAP]  = trap_take;
      ev_set[ITU_EV_ACK]   = hw_take;
      r_d.events = r_d.events | ev_set;
      r_d.irq    = |(r_d.events & r_d.mask);

      // unimplemented program memory reads zero so runaway code traps
      r_d.rom_data = (int'(rom_addr_in) >= ROM_SIZE) ? ITU_ROM_BLANK : rom_data_in;
      r_d.ram_data = (int'(ram_addr_in) >= RAM_SIZE) ? ITU_RAM_BLANK : ram_data_in;
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         r_q          <= '0;
         r_q.processor_status_word      <= ITU_RST_BYTE;
         r_q.ctrl     <= ITU_RST_BYTE;
         r_q.pc_seen  <= ITU_RST_PC;
         r_q.state    <= ITU_ST_IDLE;
         r_q.ret_kind <= ITU_RET_PLAIN;
         r_q.wait_n   <= 1'b1;
         r_q.rom_data <= ITU_ROM_BLANK;
         r_q.ram_data <= ITU_RAM_BLANK;
      end else begin
         r_q <= r_d;
      end
   end

   assign readdata_out    = r_q.rdata;
   assign waitrequest_out = r_q.wait_n;
   assign busy_out        = r_q.busy;
   assign pc_load_out     = r_q.pc_load;
   assign stack_out       = r_q.stack;
   assign rom_data_out    = r_q.rom_data;
   assign ram_data_out    = r_q.ram_data;
   assign irq_out         = r_q.irq;

endmodule

//--- itu_irq_trap_unit_properties.sv
`timescale 1ns/100ps
module itu_irq_trap_unit_chk
   import itu_pkg::*;
#(
   parameter int ROM_SIZE = 4096,
   parameter int RAM_SIZE = 128
) (
   // clock and reset
   input wire logic         clock_in,
   input wire logic         reset_in,
   // core sequencer
   input wire logic         boundary_in,
   input wire logic         exec_valid_in,
   input wire logic [7:0]   exec_opcode_in,
   input wire logic         ret_valid_in,
   input wire logic [1:0]   ret_kind_in,
   input wire logic         busy_out,
   input wire itu_pc_load_s pc_load_out,
   input wire itu_stack_s   stack_out,
   // memory read filters
   input wire logic [14:0]  rom_addr_in,
   input wire logic [7:0]   rom_data_in,
   input wire logic [7:0]   rom_data_out,
   input wire logic [7:0]   ram_addr_in,
   input wire logic [7:0]   ram_data_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   a_trap_taken: assert property (
      exec_valid_in && exec_opcode_in == ITU_TRAP_OPCODE && !busy_out |=> busy_out && stack_out.wr)
      else $error("trap opcode not taken");
   a_push_pair: assert property ($rose(busy_out) && stack_out.wr |=>
      stack_out.wr && stack_out.addr == $past(stack_out.addr) - 8'h01)
      else $error("second push byte wrong");
   a_ack_vector: assert property ($rose(busy_out) && stack_out.wr |-> ##6
      pc_load_out.load && pc_load_out.value == ITU_VECTOR)
      else $error("vector load missing");
   a_ack_length: assert property ($rose(busy_out) && stack_out.wr |->
      busy_out [*7] ##1 !busy_out)
      else $error("acknowledge length wrong");
   a_pop_order: assert property (ret_valid_in && !busy_out && !boundary_in && !exec_valid_in
      |=> stack_out.rd ##1 (stack_out.rd && stack_out.addr == $past(stack_out.addr) + 8'h01)
      ##2 pc_load_out.load)
      else $error("return pop sequence wrong");
   a_skip_flag: assert property (ret_valid_in && ret_kind_in == ITU_RET_SKIP && !busy_out
      && !boundary_in && !exec_valid_in |-> ##4 pc_load_out.skip)
      else $error("skip flag missing");
   a_ack_boundary: assert property (
      !busy_out && !boundary_in && !exec_valid_in && !ret_valid_in |=> !busy_out)
      else $error("sequence started off a boundary");
   a_rom_blank: assert property (rom_addr_in >= ROM_SIZE |=> rom_data_out == ITU_ROM_BLANK)
      else $error("blank rom not zero");
   a_rom_pass: assert property (rom_addr_in < ROM_SIZE |=> rom_data_out == $past(rom_data_in))
      else $error("rom data not passed");
   a_ram_blank: assert property (ram_addr_in >= RAM_SIZE |=> ram_data_out == ITU_RAM_BLANK)
      else $error("blank ram not all ones");
endmodule

bind itu_irq_trap_unit itu_irq_trap_unit_chk #(.ROM_SIZE(ROM_SIZE), .RAM_SIZE(RAM_SIZE))
   itu_irq_trap_unit_chk_i (.*);

//--- itu_stack_ram.sv
`timescale 1ns/100ps
module itu_stack_ram
   import itu_pkg::*;
(
   // clock
   input  wire logic       clock_in,
   // stack port
   input  wire itu_stack_s stack_in,
   output logic [7:0]      rdata_out
);
   logic [7:0] mem [256];
   initial rdata_out = 8'h00;
   always @(posedge clock_in) begin
      if (stack_in.wr)
         mem[stack_in.addr] <= stack_in.wdata;
      // data is not held outside a read slot; it inverts each idle cycle, so a stale byte returns every second cycle
      rdata_out <= stack_in.rd ? mem[stack_in.addr] : ~rdata_out;
   end
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import itu_pkg::*;
   logic         clock_in = 1'b0;
   logic         reset_in = 1'b1;
   logic         read_in = 1'b0;
   logic         write_in = 1'b0;
   logic [7:0]   address_in = 8'h00;
   logic [31:0]  writedata_in = 32'h0, readdata_out, rd;
   logic         waitrequest_out, busy_out, irq_out, ext_irq_pin_in = 1'b0;
   logic         timer_event_in = 1'b0, boundary_in = 1'b0;
   logic         exec_valid_in = 1'b0, ret_valid_in = 1'b0;
   logic [7:0]   exec_opcode_in = 8'h00, ram_addr_in = 8'h00;
   logic [7:0]   stack_rdata_in, rom_data_out, ram_data_out;
   logic [14:0]  pc_in = 15'h0000, rom_addr_in = 15'h0000;
   logic [1:0]   ret_kind_in = 2'h0;
   itu_pc_load_s pc_load_out;
   itu_stack_s   stack_out;
   int           fails = 0, compares = 0, cyc = 0;

   itu_irq_trap_unit itu_irq_trap_unit_i (.clock_in, .reset_in, .address_in, .read_in,
      .write_in, .byteenable_in(4'hf), .writedata_in, .readdata_out, .waitrequest_out,
      .ext_irq_pin_in, .timer_event_in, .boundary_in, .exec_valid_in, .exec_opcode_in,
      .pc_in, .ret_valid_in, .ret_kind_in, .busy_out, .pc_load_out, .stack_out,
      .stack_rdata_in, .rom_addr_in, .rom_data_in(8'h5a), .rom_data_out, .ram_addr_in,
      .ram_data_in(8'h3c), .ram_data_out, .irq_out);
   itu_stack_ram itu_stack_ram_i (.clock_in, .stack_in(stack_out), .rdata_out(stack_rdata_in));

   task automatic tally_and_finish;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      address_in <= a;
      writedata_in <= d;
      read_in <= !wr;
      write_in <= wr;
      @(posedge clock_in iff waitrequest_out === 1'b0);
      rd = readdata_out;
      read_in <= 1'b0;
      write_in <= 1'b0;
   endtask
   task automatic core(input logic b, input logic t, input logic x);
      @(posedge clock_in);
      boundary_in <= b;
      timer_event_in <= t;
      exec_valid_in <= x;
      @(posedge clock_in);
      boundary_in <= 1'b0;
      timer_event_in <= 1'b0;
      exec_valid_in <= 1'b0;
   endtask
   task automatic ack_seen;
      @(posedge clock_in iff pc_load_out.load === 1'b1);
      chk(pc_load_out.value, ITU_VECTOR);
   endtask
   task automatic ret(input logic [1:0] k, input logic [14:0] pc, input logic [7:0] sp);
      @(posedge clock_in);
      ret_valid_in <= 1'b1;
      ret_kind_in <= k;
      @(posedge clock_in);
      ret_valid_in <= 1'b0;
      @(posedge clock_in iff pc_load_out.load === 1'b1);
      chk(pc_load_out.value, pc);
      chk(pc_load_out.skip, k == ITU_RET_SKIP);
      bus(1'b0, ITU_OFF_STACK_PTR, 32'h0);
      chk(rd, sp);
   endtask

   task automatic s_reset;
      for (int a = 0; a <= 8'h18; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         chk(rd, 32'h0);
      end
   endtask
   task automatic s_trap;
      bus(1'b1, ITU_OFF_STACK_PTR, 32'h40);
      bus(1'b1, ITU_OFF_STATUS_WORD, 32'h01);
      pc_in <= 15'h1234;
      core(1'b0, 1'b0, 1'b1);
      ack_seen();
      chk(itu_stack_ram_i.mem[8'h40], 8'h12);
      chk(itu_stack_ram_i.mem[8'h3f], 8'h34);
      bus(1'b0, ITU_OFF_STATUS_WORD, 32'h0);
      chk(rd[0], 1'b1);
      bus(1'b0, ITU_OFF_EVENTS, 32'h0);
      chk(rd[ITU_EV_TRAP], 1'b1);
      ret(ITU_RET_SKIP, 15'h1234, 8'h40);
   endtask
   task automatic s_ext;
      bus(1'b1, ITU_OFF_CONTROL, 32'h4);
      bus(1'b1, ITU_OFF_STATUS_WORD, 32'h03);
      ext_irq_pin_in <= 1'b1;
      tick(6);
      bus(1'b0, ITU_OFF_STATUS_WORD, 32'h0);
      chk(rd[ITU_PSW_EXT_IRQ_PENDING], 1'b0);
      ext_irq_pin_in <= 1'b0;
      pc_in <= 15'h0456;
      tick(6);
      core(1'b1, 1'b0, 1'b0);
      ack_seen();
      bus(1'b0, ITU_OFF_STATUS_WORD, 32'h0);
      chk(rd[5:0], 6'h06);
      bus(1'b1, ITU_OFF_STATUS_WORD, 32'h02);
      bus(1'b0, ITU_OFF_STATUS_WORD, 32'h0);
      chk(rd[ITU_PSW_EXT_IRQ_PENDING], 1'b0);
      ret(ITU_RET_IRQ, 15'h0456, 8'h40);
      bus(1'b0, ITU_OFF_STATUS_WORD, 32'h0);
      chk(rd[ITU_PSW_GIE], 1'b1);
   endtask
   task automatic s_timer;
      bus(1'b1, ITU_OFF_STATUS_WORD, 32'h10);
      core(1'b0, 1'b1, 1'b0);
      core(1'b1, 1'b0, 1'b0);
      bus(1'b0, ITU_OFF_STACK_PTR, 32'h0);
      chk(rd, 32'h40);
      // writing one to a set pending bit keeps it either way
      bus(1'b1, ITU_OFF_STATUS_WORD, 32'h31);
      pc_in <= 15'h0777;
      core(1'b1, 1'b0, 1'b0);
      ack_seen();
      bus(1'b0, ITU_OFF_STATUS_WORD, 32'h0);
      chk(rd[5:0], 6'h30);
      ret(ITU_RET_PLAIN, 15'h0777, 8'h40);
   endtask
   task automatic s_irq_and_filters;
      bus(1'b0, ITU_OFF_EVENTS, 32'h0);
      bus(1'b1, ITU_OFF_EVENT_MASK, 32'h2);
      core(1'b0, 1'b1, 1'b0);
      tick(3);
      chk(irq_out, 1'b1);
      bus(1'b0, ITU_OFF_EVENTS, 32'h0);
      chk(rd[ITU_EV_TIMER], 1'b1);
      tick(3);
      chk(irq_out, 1'b0);
      bus(1'b1, ITU_OFF_STACK_PTR, 32'h7f);
      ret(ITU_RET_PLAIN, 15'h7fff, 8'h81);
      for (int i = 0; i < 2; i++) begin
         rom_addr_in <= i ? 15'h7fff : 15'h0fff;
         ram_addr_in <= i ? 8'hff : 8'h7f;
         tick(2);
         chk(rom_data_out, i ? ITU_ROM_BLANK : 8'h5a);
         chk(ram_data_out, i ? ITU_RAM_BLANK : 8'h3c);
      end
   endtask

   initial forever #10 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      tick(3);
      reset_in <= 1'b0;
      s_reset();
      s_trap();
      s_ext();
      s_timer();
      s_irq_and_filters();
      tally_and_finish();
   end
endmodule
